// >>> common/mac_datapath_pkg.sv
// constants, field layouts and operation codes of the multiply-accumulate
// datapath; shared by the design and by the verification side.
// assumes a 32-bit apb register port and a 16-bit core data path.
package mac_datapath_pkg;

    // widths of the core words
    localparam int DATA_W      = 16;
    localparam int ACC_W       = 32;
    localparam int ADDR_W      = 12;
    localparam int INSHIFT_W   = 5;
    localparam int OUTSHIFT_W  = 3;

    // register byte offsets on the apb port
    localparam logic [ADDR_W-1:0] OFFS_FIRST_STATUS  = 12'h000;
    localparam logic [ADDR_W-1:0] OFFS_SECOND_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFFS_ACCUMULATOR   = 12'h008;
    localparam logic [ADDR_W-1:0] OFFS_PRODUCT       = 12'h00c;
    localparam logic [ADDR_W-1:0] OFFS_OPERAND       = 12'h010;

    // first status register fields
    localparam int SAT_MODE_BIT = 11;
    localparam int OVF_BIT      = 12;
    // second status register fields
    localparam int PSCL_LSB     = 0;
    localparam int CARRY_BIT    = 9;
    localparam int SEXT_BIT     = 10;
    localparam int TEST_BIT     = 11;

    // reset values
    localparam logic       RST_CARRY = 1'b1;
    localparam logic       RST_OVF   = 1'b0;
    localparam logic       RST_SAT   = 1'b0;
    localparam logic       RST_SEXT  = 1'b1;
    localparam logic       RST_TEST  = 1'b0;
    localparam logic [1:0] RST_PSCL  = 2'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // product shift select encodings
    localparam logic [1:0] PSCL_NONE   = 2'h0;
    localparam logic [1:0] PSCL_LEFT1  = 2'h1;
    localparam logic [1:0] PSCL_LEFT4  = 2'h2;
    localparam logic [1:0] PSCL_RIGHT6 = 2'h3;

    // saturation limits and the widest input shift
    localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
    localparam logic [31:0] SAT_NEG = 32'h8000_0000;
    localparam logic [INSHIFT_W-1:0] INSHIFT_MAX = 5'h10;

    // operations issued by the core decode logic
    typedef enum logic [4:0] {
        OP_NOP, OP_LOAD_OPERAND, OP_MPY, OP_MULU,
        OP_LOAD_ACC, OP_ADD, OP_SUB, OP_ADD_PROD, OP_SUB_PROD,
        OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_ROL, OP_ROR,
        OP_NORMALIZE_OP, OP_BIT_TEST, OP_SET_CARRY, OP_CLR_CARRY,
        OP_STORE_ACC_HIGH, OP_STORE_ACC_LOW,
        OP_STORE_PROD_HIGH, OP_STORE_PROD_LOW
    } dp_op_e;

endpackage : mac_datapath_pkg

// >>> testbench/mac_core_ctrl_model.sv
// model of the core decode logic that issues one operation at a time
// assumes the datapath takes an op at the edge where op_valid is high
`timescale 1ns/100ps
module mac_core_ctrl_model
    import mac_datapath_pkg::*;
(
    input  wire logic pclk,
    output logic      op_valid,
    output dp_op_e    op_code,
    output logic [15:0] data_read_bus,
    output logic [15:0] program_read_bus,
    output logic      use_program_bus,
    output logic [4:0] shift_count,
    output logic      shift_by_operand,
    output logic [2:0] store_shift
);
    initial
    begin
        op_valid = 0; op_code = OP_NOP; data_read_bus = 16'h0;
        program_read_bus = 16'h0; use_program_bus = 0; shift_count = 5'h0;
        shift_by_operand = 0; store_shift = 3'h0;
    end
    // one-cycle pulse; the unused bus carries the inverse so a wrong pick
    // shows; after the op the data bus gets ~d and the program bus d, since their data is stale
    task run(input dp_op_e c, input logic [15:0] d, input logic pb,
             input logic [4:0] sc, input logic [2:0] ss);
        @(posedge pclk);
        op_valid <= 1; op_code <= c; use_program_bus <= pb;
        data_read_bus <= pb ? ~d : d; program_read_bus <= pb ? d : ~d;
        shift_count <= sc; store_shift <= ss;
        @(posedge pclk);
        op_valid <= 0; data_read_bus <= ~d; program_read_bus <= d;
    endtask : run
endmodule : mac_core_ctrl_model

// >>> testbench/mac_datapath_sva.sv
// port checker for the multiply-accumulate datapath
// assumes binding to the top module; one clock, async active-low reset
`timescale 1ns/100ps
module mac_datapath_sva
    import mac_datapath_pkg::*;
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic                  op_valid,
    input wire mac_datapath_pkg::dp_op_e op_code,
    input wire logic                  data_write_valid,
    input wire logic                  carry_flag,
    input wire logic                  overflow_flag,
    input wire logic                  test_flag,
    input wire logic                  acc_is_zero,
    input wire logic                  acc_is_negative
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // software writes may legally move any flag
    wire apb_wr = psel && penable && pwrite;
    // one store issued with no op right behind it
    sequence s_store;
        op_valid && op_code >= OP_STORE_ACC_HIGH ##1 !op_valid;
    endsequence
    property p_store;
        s_store |-> data_write_valid ##1 !data_write_valid;
    endproperty
    a_store: assert property (p_store)
        else $error("store pulse missing or too long");
    property p_wr_cause;
        data_write_valid |-> $past(op_valid)
            && $past(op_code) >= OP_STORE_ACC_HIGH;
    endproperty
    a_wr_cause: assert property (p_wr_cause)
        else $error("store pulse without a store op");
    property p_ovf_sticky;
        overflow_flag && !apb_wr |=> overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag dropped by itself");
    property p_ovf_cause;
        $rose(overflow_flag) |-> $past(op_valid) || $past(apb_wr);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("overflow flag rose with no cause");
    // the old accumulator sign bit must land in the carry
    property p_shl_carry;
        op_valid && op_code == OP_SHL && !apb_wr
            |=> carry_flag == $past(acc_is_negative);
    endproperty
    a_shl_carry: assert property (p_shl_carry)
        else $error("left shift did not move the msb to carry");
    property p_logic_flags;
        op_valid && op_code inside {OP_AND, OP_OR, OP_XOR} && !apb_wr
            |=> $stable(carry_flag) && $stable(overflow_flag);
    endproperty
    a_logic_flags: assert property (p_logic_flags)
        else $error("logic op moved a flag");
    property p_idle_hold;
        !op_valid && !apb_wr |=> $stable(carry_flag) && $stable(test_flag);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("flag moved while idle");
    property p_clr_carry;
        op_valid && op_code == OP_CLR_CARRY && !apb_wr |=> !carry_flag;
    endproperty
    a_clr_carry: assert property (p_clr_carry)
        else $error("carry not cleared");
endmodule : mac_datapath_sva
bind multiply_accumulate_datapath mac_datapath_sva chk_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .op_valid(op_valid), .op_code(op_code),
    .data_write_valid(data_write_valid), .carry_flag(carry_flag),
    .overflow_flag(overflow_flag), .test_flag(test_flag),
    .acc_is_zero(acc_is_zero), .acc_is_negative(acc_is_negative));

// >>> testbench/multiply_accumulate_datapath_tb.sv
// self-checking bench: apb master tasks, decode model, scenario tasks
// assumes zero-wait apb answers and results visible the cycle after an op
`timescale 1ns/100ps
module multiply_accumulate_datapath_tb;
    import mac_datapath_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, op_valid, use_program_bus, shift_by_operand;
    logic data_write_valid, carry_flag, overflow_flag, test_flag;
    logic acc_is_zero, acc_is_negative;
    dp_op_e op_code;
    logic [15:0] data_read_bus, program_read_bus, data_write_bus;
    logic [4:0] shift_count;
    logic [2:0] store_shift;
    int bad_count = 0, cmp_count = 0;
    always #10 pclk = ~pclk;
    mac_core_ctrl_model ctl (.*);
    multiply_accumulate_datapath DUT (.*);
    // one apb transfer; held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata; rerr = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(rdat, exp);
    endtask : rchk
    // reset values and an unmapped place
    task t_reset;
        rchk(OFFS_SECOND_STATUS, 32'h0000_0600);
        rchk(OFFS_FIRST_STATUS, 32'h0);
        apb(0, 12'h020, 32'h0);
        chk(rerr, 1);
    endtask : t_reset
    // signed, unsigned and scaled products
    task t_mult;
        logic [31:0] e[4];
        e = '{32'hff80_0100, 32'hff00_0200, 32'hf800_1000, 32'hfffe_0004};
        ctl.run(OP_LOAD_OPERAND, 16'h8001, 0, 0, 0);
        ctl.run(OP_MULU, 16'h0100, 1, 0, 0);
        rchk(OFFS_PRODUCT, 32'h0080_0100);
        ctl.run(OP_MPY, 16'h0100, 0, 0, 0);
        apb(1, OFFS_PRODUCT, 32'h0);
        rchk(OFFS_PRODUCT, e[0]);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, OFFS_SECOND_STATUS, 32'h0000_0400 | i);
            ctl.run(OP_STORE_PROD_HIGH, 16'h0, 0, 0, 0);
            #1 chk(data_write_bus, e[i][31:16]);
            ctl.run(OP_STORE_PROD_LOW, 16'h0, 0, 0, 0);
            #1 chk(data_write_bus, e[i][15:0]);
        end
        rchk(OFFS_PRODUCT, e[0]);
        apb(1, OFFS_ACCUMULATOR, 32'h0);
        ctl.run(OP_ADD_PROD, 16'h0, 0, 0, 0);
        rchk(OFFS_ACCUMULATOR, e[3]);
    endtask : t_mult
    // overflow wraps, then saturates both ways; flag stays latched
    task t_ovf;
        apb(1, OFFS_ACCUMULATOR, 32'h7fff_ffff);
        ctl.run(OP_ADD, 16'h1, 0, 0, 0);
        rchk(OFFS_ACCUMULATOR, 32'h8000_0000);
        chk(overflow_flag, 1);
        apb(1, OFFS_FIRST_STATUS, 32'h0000_0800);
        apb(1, OFFS_ACCUMULATOR, 32'h7fff_ffff);
        ctl.run(OP_ADD, 16'h1, 0, 0, 0);
        rchk(OFFS_ACCUMULATOR, 32'h7fff_ffff);
        ctl.run(OP_AND, 16'h0, 0, 0, 0);
        #1 chk(overflow_flag, 1);
        apb(1, OFFS_ACCUMULATOR, 32'h8000_0000);
        ctl.run(OP_SUB, 16'h1, 0, 0, 0);
        rchk(OFFS_ACCUMULATOR, 32'h8000_0000);
        apb(1, OFFS_FIRST_STATUS, 32'h0);
    endtask : t_ovf
    // carry on add/sub, the shift-16 exception and single-bit shifts
    task t_carry;
        apb(1, OFFS_ACCUMULATOR, 32'hffff_ffff);
        ctl.run(OP_ADD, 16'h1, 0, 0, 0);
        #1 chk({carry_flag, acc_is_zero}, 2'b11);
        ctl.run(OP_ADD, 16'h1, 0, 0, 0);
        #1 chk(carry_flag, 0);
        ctl.run(OP_SUB, 16'h1, 0, 0, 0);
        #1 chk(carry_flag, 1);
        ctl.run(OP_SET_CARRY, 16'h0, 0, 0, 0);
        ctl.run(OP_ADD, 16'h1, 0, 5'h10, 0);
        #1 chk(carry_flag, 1);
        ctl.run(OP_CLR_CARRY, 16'h0, 0, 0, 0);
        ctl.run(OP_SUB, 16'h1, 0, 5'h10, 0);
        #1 chk(carry_flag, 0);
        apb(1, OFFS_ACCUMULATOR, 32'h8000_0001);
        ctl.run(OP_SHL, 16'h0, 0, 0, 0);
        #1 chk(carry_flag, 1);
        ctl.run(OP_SHR, 16'h0, 0, 0, 0);
        #1 chk(carry_flag, 0);
        ctl.run(OP_ROR, 16'h0, 0, 0, 0);
        #1 chk({carry_flag, acc_is_zero}, 2'b11);
        ctl.run(OP_ROL, 16'h0, 0, 0, 0);
        rchk(OFFS_ACCUMULATOR, 32'h1);
    endtask : t_carry
    // input shifter, output shifter, normalize and bit test
    task t_shift;
        apb(1, OFFS_SECOND_STATUS, 32'h0);
        ctl.run(OP_LOAD_ACC, 16'h8000, 0, 5'h8, 0);
        rchk(OFFS_ACCUMULATOR, 32'h0080_0000);
        apb(1, OFFS_SECOND_STATUS, 32'h0000_0400);
        ctl.run(OP_LOAD_ACC, 16'h8000, 1, 5'h8, 0);
        rchk(OFFS_ACCUMULATOR, 32'hff80_0000);
        chk(acc_is_negative, 1);
        apb(1, OFFS_ACCUMULATOR, 32'h1234_5678);
        ctl.run(OP_STORE_ACC_HIGH, 16'h0, 0, 0, 3'h4);
        #1 chk(data_write_bus, 16'h2345);
        ctl.run(OP_STORE_ACC_HIGH, 16'h0, 0, 0, 3'h7);
        #1 chk(data_write_bus, 16'h1a2b);
        ctl.run(OP_STORE_ACC_LOW, 16'h0, 0, 0, 3'h6);
        #1 chk(data_write_bus, 16'h9e00);
        rchk(OFFS_ACCUMULATOR, 32'h1234_5678);
        apb(1, OFFS_ACCUMULATOR, 32'h2000_0000);
        ctl.run(OP_NORMALIZE_OP, 16'h0, 0, 0, 0);
        #1 chk(test_flag, 0);
        ctl.run(OP_NORMALIZE_OP, 16'h0, 0, 0, 0);
        #1 chk(test_flag, 1);
        ctl.run(OP_BIT_TEST, 16'h0010, 0, 5'h3, 0);
        #1 chk(test_flag, 0);
        ctl.run(OP_BIT_TEST, 16'h0010, 0, 5'h4, 0);
        #1 chk(test_flag, 1);
        ctl.run(OP_LOAD_OPERAND, 16'h0003, 0, 0, 0);
        ctl.shift_by_operand <= 1;
        ctl.run(OP_LOAD_ACC, 16'h0001, 0, 5'h0, 0);
        ctl.shift_by_operand <= 0;
        rchk(OFFS_ACCUMULATOR, 32'h8);
    endtask : t_shift
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    // watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        #100000;
        bad_count++;
        stop_test();
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_mult();
        t_ovf();
        t_carry();
        t_shift();
        stop_test();
    end
endmodule : multiply_accumulate_datapath_tb

// >>> verilog/multiply_accumulate_datapath.sv
// multiply-accumulate datapath: operand register, multiplier, product
// register and scaler, central alu with accumulator and flags, output shifter.
// assumes ops come from decode logic on pclk (no synchroniser needed) and
// status/accumulator are reachable by software over apb.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module multiply_accumulate_datapath
(
    input  wire  logic                                      pclk,
    input  wire  logic                                      presetn,
    // apb slave
    input  wire  logic                                      psel,
    input  wire  logic                                      penable,
    input  wire  logic                                      pwrite,
    input  wire  logic [mac_datapath_pkg::ADDR_W-1:0]       paddr,
    input  wire  logic [31:0]                               pwdata,
    output logic       [31:0]                               prdata,
    output logic                                            pready,
    output logic                                            pslverr,
    // operation port from decode logic
    input  wire  logic                                      op_valid,
    input  wire  mac_datapath_pkg::dp_op_e                  op_code,
    input  wire  logic [mac_datapath_pkg::DATA_W-1:0]       data_read_bus,
    input  wire  logic [mac_datapath_pkg::DATA_W-1:0]       program_read_bus,
    input  wire  logic                                      use_program_bus,
    input  wire  logic [mac_datapath_pkg::INSHIFT_W-1:0]    shift_count,
    input  wire  logic                                      shift_by_operand,
    input  wire  logic [mac_datapath_pkg::OUTSHIFT_W-1:0]   store_shift,
    // store path to data memory
    output logic       [mac_datapath_pkg::DATA_W-1:0]       data_write_bus,
    output logic                                            data_write_valid,
    // branch conditions
    output logic                                            carry_flag,
    output logic                                            overflow_flag,
    output logic                                            test_flag,
    output logic                                            acc_is_zero,
    output logic                                            acc_is_negative
);
    import mac_datapath_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // add with carry-in; returns {carry, signed overflow, sum}
    function automatic logic [33:0] add_flags
    (
        input logic [31:0] a,
        input logic [31:0] b,
        input logic        cin
    );
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
        add_flags = {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
    endfunction : add_flags

    // scales a copy of the product; the register itself is never touched
    function automatic logic [31:0] prod_shift
    (
        input logic [31:0] p,
        input logic [1:0]  ps
    );
        logic [31:0] r;
        r = p;
        unique case (ps)
            PSCL_NONE:   r = p;
            PSCL_LEFT1:  r = {p[30:0], 1'b0};
            PSCL_LEFT4:  r = {p[27:0], 4'h0};
            PSCL_RIGHT6: r = {{6{p[31]}}, p[31:6]};
        endcase
        prod_shift = r;
    endfunction : prod_shift

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0] acc_q,   acc_d;        // main_accumulator
    logic [15:0] oreg_q,  oreg_d;       // multiplier_operand_reg
    logic [31:0] prod_q,  prod_d;       // product_reg
    logic        carry_q, carry_d;      // carry flag
    logic        ovf_q,   ovf_d;        // sticky overflow_flag
    logic        test_q,  test_d;       // test_flag
    logic        sat_q;                 // saturation_mode
    logic        sext_q;                // sign_extension_mode
    logic [1:0]  pscl_q;                // product_shift_select
    logic [15:0] dwb_q,   dwb_d;        // data_write_bus word
    logic        dwv_q,   dwv_d;        // store strobe
    logic [31:0] rdata_q;               // apb read data

    // ------------------------------------------------------------------
    // apb decode: zero wait, unmapped addresses answer with pslverr
    // ------------------------------------------------------------------
    wire apb_setup  = psel & ~penable;
    wire apb_access = psel & penable;
    wire hit_sr0    = (paddr == OFFS_FIRST_STATUS);
    wire hit_sr1    = (paddr == OFFS_SECOND_STATUS);
    wire hit_acc    = (paddr == OFFS_ACCUMULATOR);
    wire hit_prod   = (paddr == OFFS_PRODUCT);
    wire hit_oreg   = (paddr == OFFS_OPERAND);
    wire addr_hit   = hit_sr0 | hit_sr1 | hit_acc | hit_prod | hit_oreg;
    wire wr_en      = apb_access & pwrite & addr_hit;
    wire wr_sr0     = wr_en & hit_sr0;
    wire wr_sr1     = wr_en & hit_sr1;
    wire wr_acc     = wr_en & hit_acc;
    wire wr_oreg    = wr_en & hit_oreg;

    assign pready  = 1'b1;
    assign pslverr = apb_access & ~addr_hit;
    assign prdata  = rdata_q;

    // readback words; bits not listed read as zero
    wire [31:0] sr0_word = (32'(sat_q) << SAT_MODE_BIT)
                         | (32'(ovf_q) << OVF_BIT);
    wire [31:0] sr1_word = (32'(pscl_q)  << PSCL_LSB)
                         | (32'(carry_q) << CARRY_BIT)
                         | (32'(sext_q)  << SEXT_BIT)
                         | (32'(test_q)  << TEST_BIT);
    wire [31:0] rd_word  = hit_sr0  ? sr0_word :
                           hit_sr1  ? sr1_word :
                           hit_acc  ? acc_q    :
                           hit_prod ? prod_q   :
                           hit_oreg ? {16'h0, oreg_q} : RST_WORD;

    // ------------------------------------------------------------------
    // operand selection and the three shifters
    // ------------------------------------------------------------------

    // second bus operand: data read bus or program read bus
    wire [15:0] bus_word = use_program_bus ? program_read_bus
                                           : data_read_bus;

    // input shift count: from the op or the low nibble of the operand reg;
    // anything beyond sixteen is clamped, the shifter has no wider range
    wire [4:0] cnt_raw   = shift_by_operand ? {1'b0, oreg_q[3:0]}
                                            : shift_count;
    wire [4:0] in_cnt    = (cnt_raw > INSHIFT_MAX) ? INSHIFT_MAX : cnt_raw;
    wire       shift16   = (in_cnt == INSHIFT_MAX);

    // input shifter: zero-filled lsbs, msbs sign extended only in sign mode
    wire [31:0] in_ext   = sext_q ? {{16{bus_word[15]}}, bus_word}
                                 : {16'h0, bus_word};
    wire [31:0] in_val   = in_ext << in_cnt;

    // product scaler works on a copy of the product register
    wire [31:0] prod_scaled = prod_shift(prod_q, pscl_q);

    // multiplier: signed or unsigned, full 32-bit product
    wire signed [31:0] mul_s = $signed(oreg_q) * $signed(bus_word);
    wire        [31:0] mul_u = oreg_q * bus_word;

    // output shifter: copy of the accumulator, msbs lost, lsbs zeroed
    wire [31:0] out_val  = acc_q << store_shift;

    // alu second operand: product scaler or input shifter
    wire        use_prod = (op_code == OP_ADD_PROD)
                         | (op_code == OP_SUB_PROD);
    wire [31:0] alu_b    = use_prod ? prod_scaled : in_val;
    wire        is_sub   = (op_code == OP_SUB) | (op_code == OP_SUB_PROD);

    // adder shared by add and subtract; subtract is a + ~b + 1
    wire [33:0] sum_f    = add_flags(acc_q, is_sub ? ~alu_b : alu_b,
                                     is_sub);
    wire        sum_c    = sum_f[33];
    wire        sum_v    = sum_f[32];
    wire [31:0] sum_r    = sum_f[31:0];

    // overflow direction follows the accumulator sign before the op
    wire [31:0] sat_val  = acc_q[31] ? SAT_NEG : SAT_POS;
    wire [31:0] arith_r  = (sum_v & sat_q) ? sat_val : sum_r;

    // tested bit index comes from the low nibble of the shift count
    wire        bit_sel  = bus_word[shift_count[3:0]];
    wire        normalize_op_set = acc_q[31] ^ acc_q[30];

    // ------------------------------------------------------------------
    // next-state logic of the datapath
    // ------------------------------------------------------------------
    // an op wins over a software write to the same state in the same
    // cycle; the overflow flag is sticky so a hardware set beats any clear
    always_comb
    begin
        acc_d   = wr_acc  ? pwdata : acc_q;
        oreg_d  = wr_oreg ? pwdata[15:0] : oreg_q;
        prod_d  = prod_q;
        carry_d = wr_sr1 ? pwdata[CARRY_BIT] : carry_q;
        test_d  = wr_sr1 ? pwdata[TEST_BIT]  : test_q;
        ovf_d   = wr_sr0 ? pwdata[OVF_BIT]   : ovf_q;
        dwb_d   = dwb_q;
        dwv_d   = 1'b0;
        if (op_valid)
        begin
            unique case (op_code)
                OP_NOP:
                begin
                end
                OP_LOAD_OPERAND:
                    oreg_d = data_read_bus;
                OP_MPY:
                    prod_d = mul_s;
                OP_MULU:
                    prod_d = mul_u;
                OP_LOAD_ACC:
                    acc_d = in_val;
                OP_ADD, OP_ADD_PROD:
                begin
                    acc_d = arith_r;
                    // shift-16 add may only set the carry
                    if (!(shift16 & !use_prod) || sum_c)
                        carry_d = sum_c;
                    if (sum_v)
                        ovf_d = 1'b1;
                end
                OP_SUB, OP_SUB_PROD:
                begin
                    acc_d = arith_r;
                    // carry out of a + ~b + 1 means no borrow
                    if (!(shift16 & !use_prod) || !sum_c)
                        carry_d = sum_c;
                    if (sum_v)
                        ovf_d = 1'b1;
                end
                OP_AND:
                    acc_d = acc_q & in_val;
                OP_OR:
                    acc_d = acc_q | in_val;
                OP_XOR:
                    acc_d = acc_q ^ in_val;
                OP_SHL:
                begin
                    carry_d = acc_q[31];
                    acc_d   = {acc_q[30:0], 1'b0};
                end
                OP_SHR:
                begin
                    carry_d = acc_q[0];
                    acc_d   = {sext_q & acc_q[31], acc_q[31:1]};
                end
                OP_ROL:
                begin
                    carry_d = acc_q[31];
                    acc_d   = {acc_q[30:0], carry_q};
                end
                OP_ROR:
                begin
                    carry_d = acc_q[0];
                    acc_d   = {carry_q, acc_q[31:1]};
                end
                OP_NORMALIZE_OP:
                begin
                    test_d = normalize_op_set;
                    // not yet normalised: move one step left
                    if (!normalize_op_set && (acc_q != RST_WORD))
                        acc_d = {acc_q[30:0], 1'b0};
                end
                OP_BIT_TEST:
                    test_d = bit_sel;
                OP_SET_CARRY:
                    carry_d = 1'b1;
                OP_CLR_CARRY:
                    carry_d = 1'b0;
                OP_STORE_ACC_HIGH:
                begin
                    dwb_d = out_val[31:16];
                    dwv_d = 1'b1;
                end
                OP_STORE_ACC_LOW:
                begin
                    dwb_d = out_val[15:0];
                    dwv_d = 1'b1;
                end
                OP_STORE_PROD_HIGH:
                begin
                    dwb_d = prod_scaled[31:16];
                    dwv_d = 1'b1;
                end
                OP_STORE_PROD_LOW:
                begin
                    dwb_d = prod_scaled[15:0];
                    dwv_d = 1'b1;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // datapath registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q   <= RST_WORD;
            oreg_q  <= RST_WORD[15:0];
            prod_q  <= RST_WORD;
            carry_q <= RST_CARRY;
            ovf_q   <= RST_OVF;
            test_q  <= RST_TEST;
            dwb_q   <= RST_WORD[15:0];
            dwv_q   <= 1'b0;
        end
        else
        begin
            acc_q   <= acc_d;
            oreg_q  <= oreg_d;
            prod_q  <= prod_d;
            carry_q <= carry_d;
            ovf_q   <= ovf_d;
            test_q  <= test_d;
            dwb_q   <= dwb_d;
            dwv_q   <= dwv_d;
        end
    end

    // ------------------------------------------------------------------
    // mode bits, written only by software
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sat_q <= RST_SAT;
            sext_q <= RST_SEXT;
            pscl_q <= RST_PSCL;
        end
        else
        begin
            if (wr_sr0)
                sat_q <= pwdata[SAT_MODE_BIT];
            if (wr_sr1)
            begin
                sext_q <= pwdata[SEXT_BIT];
                pscl_q <= pwdata[PSCL_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------------
    // read data is captured in the setup phase, so it shows the state
    // one cycle before the access; an op in that gap is not reflected
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= RST_WORD;
        else if (apb_setup)
            rdata_q <= rd_word;
    end

    // ------------------------------------------------------------------
    // outputs towards memory and branch control
    // ------------------------------------------------------------------
    assign data_write_bus   = dwb_q;
    assign data_write_valid = dwv_q;
    assign carry_flag       = carry_q;
    assign overflow_flag    = ovf_q;
    assign test_flag        = test_q;
    assign acc_is_zero      = (acc_q == RST_WORD);
    assign acc_is_negative  = acc_q[31];

endmodule : multiply_accumulate_datapath
